/* rtl/cbsc_pkg.sv */
// Package: constants and carriers for the counter bus strobe control
package cbsc_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 16;
  localparam int ADDR_SEL_BIT = 5;
  localparam int FILTER_BIT = 0;
  localparam int COUNT_W = 8;
  localparam int DISP_DEPTH = 16;
  localparam int DISP_AW = 4;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] RST_DIV = 2'h0;
  localparam logic [3:0] RST_DISP_PTR = 4'h0;
  localparam logic RST_BIT = 1'b0;
  localparam logic RST_BIT_HI = 1'b1;

  // Synchronised processor strobes, as raw pin levels
  typedef struct packed {
    logic disp_wr;
    logic cnt_rd_n;
    logic src_wr_n;
    logic tim_rd_n;
    logic tim_wr_n;
    logic divh_n;
    logic divl_n;
    logic pd_wr_n;
    logic pd_rd_n;
    logic kbd_n;
    logic dac_n;
    logic pwr_n;
  } cbsc_strobe_t;

  // Data bus pin pair
  typedef struct packed {
    logic [DATA_W-1:0] dout;
    logic oe;
  } cbsc_dbus_t;
endpackage : cbsc_pkg

/* rtl/cbsc_top.sv */
// Strobe decode and peripheral actions of the frequency counter processor bus
import cbsc_pkg::*;

//Contract
// - Display write stores; low shows RAM
// - Counter read drives A or B, bit5
// - Counter write sets count source flip-flop
// - Timing read drives timing data
// - Timing write clocks input register
// - High load rising edge loads divider high
// - Low load rising edge loads divider low
// - Power write low starts detection
// - Power write high picks filter bit0
// - Power read drives detector result
// - Keypad strobe drives keyboard data
// - Analog load latches DAC buffer
// - Keypad or interface pulls interrupt
// - Direct gate enables main gate
// - IF gate enables counter A/B
// - Oscillator select steps with counters
// - Main gate clear pulse to amplifier
// - Direct outputs divide by two, four
// - Power strobe enables trigger decoder
module cbsc_top import cbsc_pkg::*; (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [ADDR_W-1:0] address_bus,
  input wire logic [DATA_W-1:0] data_in,
  output logic [DATA_W-1:0] data_out,
  output logic data_oe,
  input wire logic display_ram_write,
  input wire logic count_read_n,
  input wire logic count_source_write_n,
  input wire logic timing_read_n,
  input wire logic timing_write_n,
  input wire logic divider_high_load_n,
  input wire logic divider_low_load_n,
  input wire logic power_detect_write_n,
  input wire logic power_detect_read_n,
  input wire logic keypad_read_n,
  input wire logic analog_out_load_n,
  input wire logic display_blank_reset_n,
  input wire logic trigger_decoder_enable_n,
  input wire logic interface_card_select_n,
  input wire logic direct_in,
  input wire logic if_in,
  input wire logic [DATA_W-1:0] keypad_code,
  input wire logic [DATA_W-1:0] power_level,
  input wire logic key_pending,
  input wire logic interface_irq,
  input wire logic gate_open,
  output logic [DATA_W-1:0] display_data,
  output logic display_blank,
  output logic [DATA_W-1:0] analog_out,
  output logic [2*DATA_W-1:0] divide_n,
  output logic [DATA_W-1:0] timing_reg,
  output logic count_source_if,
  output logic detect_active,
  output logic narrow_filter,
  output logic interrupt_request_n,
  output logic direct_gate_n,
  output logic if_gate_n,
  output logic oscillator_select,
  output logic main_gate_clear,
  output logic direct_div2,
  output logic direct_div4,
  output logic trigger_enable,
  output logic interface_enable
);

  // Two-stage synchronisers for strobe, address, data and misc pins; gate_open, keypad_code and power_level are used raw
  cbsc_strobe_t s1_r, s2_r, s3_r, s_nxt;
  logic [ADDR_W-1:0] a1_r, a2_r;
  logic [DATA_W-1:0] d1_r, d2_r;
  logic [5:0] m1_r, m2_r, m_nxt;

  always_comb begin
    s_nxt = '{display_ram_write, count_read_n, count_source_write_n, timing_read_n,
      timing_write_n, divider_high_load_n, divider_low_load_n, power_detect_write_n,
      power_detect_read_n, keypad_read_n, analog_out_load_n, trigger_decoder_enable_n};
    m_nxt = {display_blank_reset_n, interface_card_select_n, direct_in, if_in,
      key_pending, interface_irq};
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      // Idle pin levels, so no false strobe edge follows reset
      s1_r <= '{disp_wr: RST_BIT, default: RST_BIT_HI};
      s2_r <= '{disp_wr: RST_BIT, default: RST_BIT_HI};
      s3_r <= '{disp_wr: RST_BIT, default: RST_BIT_HI};
      a1_r <= '0;
      a2_r <= '0;
      d1_r <= RST_BYTE;
      d2_r <= RST_BYTE;
      m1_r <= {RST_BIT_HI, RST_BIT_HI, {4{RST_BIT}}};
      m2_r <= {RST_BIT_HI, RST_BIT_HI, {4{RST_BIT}}};
    end else begin
      s1_r <= s_nxt;
      s2_r <= s1_r;
      s3_r <= s2_r;
      a1_r <= address_bus;
      a2_r <= a1_r;
      d1_r <= data_in;
      d2_r <= d1_r;
      m1_r <= m_nxt;
      m2_r <= m1_r;
    end
  end

  function automatic logic rise(input logic prev, input logic cur);
    rise = !prev && cur;
  endfunction

  function automatic logic fall(input logic prev, input logic cur);
    fall = prev && !cur;
  endfunction

  logic blank_n, sel_n, dir_s, if_s, key_s, ifc_irq_s;
  assign {blank_n, sel_n, dir_s, if_s, key_s, ifc_irq_s} = m2_r;

  // Register state
  logic [DATA_W-1:0] disp_mem [DISP_DEPTH];
  logic [DISP_AW-1:0] wptr_r, wptr_nxt, rptr_r, rptr_nxt;
  logic [DATA_W-1:0] disp_r, disp_nxt, dac_r, dac_nxt, tim_r, tim_nxt;
  logic [DATA_W-1:0] nhi_r, nhi_nxt, nlo_r, nlo_nxt, dout_r, dout_nxt;
  logic [COUNT_W-1:0] cnta_r, cnta_nxt, cntb_r, cntb_nxt;
  logic src_r, src_nxt, narrow_r, narrow_nxt, det_r, det_nxt, oe_r, oe_nxt;
  logic blank_r, blank_nxt, irq_n_r, irq_n_nxt, osc_r, osc_nxt;
  logic dgate_n_r, dgate_n_nxt, igate_n_r, igate_n_nxt, clr_r, clr_nxt;
  logic gate_r, gate_nxt, trig_r, trig_nxt, ifce_r, ifce_nxt, dir_prev_r, dir_prev_nxt;
  logic [1:0] div_r, div_nxt;
  logic cnt_in, cin_prev_r, cin_prev_nxt;
  logic [DISP_AW-1:0] waddr;

  always_comb begin
    wptr_nxt = wptr_r;
    waddr = wptr_r;
    rptr_nxt = rptr_r;
    disp_nxt = disp_r;
    dac_nxt = dac_r;
    tim_nxt = tim_r;
    nhi_nxt = nhi_r;
    nlo_nxt = nlo_r;
    src_nxt = src_r;
    narrow_nxt = narrow_r;
    det_nxt = det_r;
    blank_nxt = blank_r;
    cnta_nxt = cnta_r;
    cntb_nxt = cntb_r;
    div_nxt = div_r;
    dir_prev_nxt = dir_s;
    gate_nxt = gate_open;
    // RAM fill while high, scan while low
    if (s2_r.disp_wr) begin
      // First byte of a fill lands at the start of RAM
      if (rise(s3_r.disp_wr, s2_r.disp_wr)) waddr = RST_DISP_PTR;
      wptr_nxt = waddr + 4'h1;
    end else begin
      rptr_nxt = rptr_r + 4'h1;
      disp_nxt = disp_mem[rptr_r];
    end
    blank_nxt = !blank_n;
    if (fall(s3_r.src_wr_n, s2_r.src_wr_n)) src_nxt = d2_r[0];
    if (fall(s3_r.tim_wr_n, s2_r.tim_wr_n)) tim_nxt = d2_r;
    // Divider high bits on rising edge
    if (rise(s3_r.divh_n, s2_r.divh_n)) nhi_nxt = d2_r;
    // Divider low bits on rising edge
    if (rise(s3_r.divl_n, s2_r.divl_n)) nlo_nxt = d2_r;
    det_nxt = !s2_r.pd_wr_n;
    // Filter choice while power write high
    if (s2_r.pd_wr_n) narrow_nxt = d2_r[FILTER_BIT];
    if (fall(s3_r.dac_n, s2_r.dac_n)) dac_nxt = d2_r;
    // Direct divide by two and four
    if (rise(dir_prev_r, dir_s)) div_nxt = div_r + 2'h1;
    // Gate routes to counter A or B by oscillator select
    cnt_in = src_r ? if_s : div_r[1];
    cin_prev_nxt = cnt_in;
    if (gate_r && rise(cin_prev_r, cnt_in)) begin
      if (osc_r) cntb_nxt = cntb_r + 8'h01;
      else cnta_nxt = cnta_r + 8'h01;
    end
    clr_nxt = gate_open && !gate_r;
    if (clr_nxt) begin
      cnta_nxt = RST_BYTE;
      cntb_nxt = RST_BYTE;
    end
  end

  always_comb begin
    dout_nxt = RST_BYTE;
    oe_nxt = 1'b1;
    // Counter read by address bit five
    if (!s2_r.cnt_rd_n) dout_nxt = a2_r[ADDR_SEL_BIT] ? cntb_r : cnta_r;
    else if (!s2_r.tim_rd_n) dout_nxt = tim_r;
    else if (!s2_r.pd_rd_n) dout_nxt = power_level;
    else if (!s2_r.kbd_n) dout_nxt = keypad_code;
    else oe_nxt = 1'b0;
    irq_n_nxt = !(key_s || ifc_irq_s);
    dgate_n_nxt = !(gate_open && !src_r);
    igate_n_nxt = !(gate_open && src_r);
    osc_nxt = clr_nxt ? !osc_r : osc_r;
    trig_nxt = !s2_r.pwr_n;
    ifce_nxt = !sel_n;
  end

  always_ff @(posedge mclk) begin
    if (s2_r.disp_wr) disp_mem[waddr] <= d2_r;
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wptr_r <= RST_DISP_PTR;
      rptr_r <= RST_DISP_PTR;
      {disp_r, dac_r, tim_r, nhi_r, nlo_r, dout_r} <= {6{RST_BYTE}};
      {cnta_r, cntb_r} <= {2{RST_BYTE}};
      {src_r, narrow_r, det_r, oe_r, osc_r, clr_r} <= {6{RST_BIT}};
      {gate_r, trig_r, ifce_r, dir_prev_r, cin_prev_r} <= {5{RST_BIT}};
      {blank_r, irq_n_r, dgate_n_r, igate_n_r} <= {4{RST_BIT_HI}};
      div_r <= RST_DIV;
    end else begin
      wptr_r <= wptr_nxt;
      rptr_r <= rptr_nxt;
      disp_r <= disp_nxt;
      dac_r <= dac_nxt;
      tim_r <= tim_nxt;
      nhi_r <= nhi_nxt;
      nlo_r <= nlo_nxt;
      dout_r <= dout_nxt;
      cnta_r <= cnta_nxt;
      cntb_r <= cntb_nxt;
      src_r <= src_nxt;
      narrow_r <= narrow_nxt;
      det_r <= det_nxt;
      oe_r <= oe_nxt;
      osc_r <= osc_nxt;
      clr_r <= clr_nxt;
      gate_r <= gate_nxt;
      trig_r <= trig_nxt;
      ifce_r <= ifce_nxt;
      dir_prev_r <= dir_prev_nxt;
      cin_prev_r <= cin_prev_nxt;
      blank_r <= blank_nxt;
      irq_n_r <= irq_n_nxt;
      dgate_n_r <= dgate_n_nxt;
      igate_n_r <= igate_n_nxt;
      div_r <= div_nxt;
    end
  end

  assign data_out = dout_r;
  assign data_oe = oe_r;
  assign display_data = disp_r;
  assign display_blank = blank_r;
  assign analog_out = dac_r;
  assign divide_n = {nhi_r, nlo_r};
  assign timing_reg = tim_r;
  assign count_source_if = src_r;
  assign detect_active = det_r;
  assign narrow_filter = narrow_r;
  assign interrupt_request_n = irq_n_r;
  assign direct_gate_n = dgate_n_r;
  assign if_gate_n = igate_n_r;
  assign oscillator_select = osc_r;
  assign main_gate_clear = clr_r;
  assign direct_div2 = div_r[0];
  assign direct_div4 = div_r[1];
  assign trigger_enable = trig_r;
  assign interface_enable = ifce_r;

  a_timing_load: assert property (@(posedge mclk) disable iff (!arst_n)
    $fell(s2_r.tim_wr_n) |=> tim_r == $past(d2_r)) else $error("timing load");
  a_div_high: assert property (@(posedge mclk) disable iff (!arst_n)
    $rose(s2_r.divh_n) |=> divide_n[15:8] == $past(d2_r)) else $error("div high");
  a_div_low: assert property (@(posedge mclk) disable iff (!arst_n)
    $rose(s2_r.divl_n) |=> divide_n[7:0] == $past(d2_r)) else $error("div low");
  a_detect_lvl: assert property (@(posedge mclk) disable iff (!arst_n)
    !s2_r.pd_wr_n |=> detect_active) else $error("detect");
  a_dac_latch: assert property (@(posedge mclk) disable iff (!arst_n)
    $fell(s2_r.dac_n) |=> analog_out == $past(d2_r)) else $error("dac");
  a_count_read: assert property (@(posedge mclk) disable iff (!arst_n)
    !s2_r.cnt_rd_n |=> data_oe) else $error("count read");
  a_blank_hold: assert property (@(posedge mclk) disable iff (!arst_n)
    !blank_n |=> display_blank) else $error("blank");
  a_irq_key: assert property (@(posedge mclk) disable iff (!arst_n)
    key_s |=> !interrupt_request_n) else $error("irq");
  a_clear_pulse: assert property (@(posedge mclk) disable iff (!arst_n)
    main_gate_clear |=> !main_gate_clear) else $error("clear");
endmodule // cbsc_top

/* test/cbsc_cpu.sv */
// Processor-side strobe driver model for the counter bus strobe control
module cbsc_cpu import cbsc_pkg::*; (
  input wire logic mclk,
  output cbsc_strobe_t stb,
  output logic [ADDR_W-1:0] address_bus,
  output logic [DATA_W-1:0] data_in,
  output logic display_blank_reset_n,
  output logic interface_card_select_n
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [13:0] IDLE = 14'h37ff;
  logic [13:0] lines = IDLE;
  assign stb = cbsc_strobe_t'(lines[11:0]);
  assign display_blank_reset_n = lines[12];
  assign interface_card_select_n = lines[13];
  initial begin
    address_bus = 16'h0000;
    data_in = 8'h5a;
  end
  task automatic begin_cycle(int idx, logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
    @(posedge mclk);
    lines <= IDLE ^ (14'h0001 << idx);
    address_bus <= a;
    data_in <= d;
  endtask
  // Released bus no longer shows the last value
  task automatic end_cycle();
    @(posedge mclk);
    lines <= IDLE;
    repeat (3) @(posedge mclk);
    data_in <= ~data_in;
    address_bus <= ~address_bus;
  endtask
endmodule // cbsc_cpu

/* test/test_counter_bus_strobe_control.sv */
// Self-checking bench for the counter bus strobe control
module test_counter_bus_strobe_control import cbsc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic [ADDR_W-1:0] address_bus;
  logic [DATA_W-1:0] data_in, data_out, keypad_code, power_level, display_data, analog_out;
  logic [DATA_W-1:0] timing_reg, d, e, lo, pl, kc;
  logic [2*DATA_W-1:0] divide_n;
  logic data_oe, display_blank, count_source_if, detect_active, narrow_filter;
  logic interrupt_request_n, direct_gate_n, if_gate_n, oscillator_select, main_gate_clear;
  logic direct_div2, direct_div4, trigger_enable, interface_enable, direct_in, if_in;
  logic key_pending, interface_irq, gate_open, display_ram_write, count_read_n;
  logic count_source_write_n, timing_read_n, timing_write_n, divider_high_load_n;
  logic divider_low_load_n, power_detect_write_n, power_detect_read_n, keypad_read_n;
  logic analog_out_load_n, display_blank_reset_n, trigger_decoder_enable_n;
  logic interface_card_select_n;
  cbsc_strobe_t stb;
  int seed = 43;
  int miscompares = 0;
  int cmp_count = 0;
  int dir_edges = 0;
  logic dir_lvl = 1'b0;
  logic [15:0] exp_q[$];
  logic [3:0] sel_q[$];
  event probe_ev;
  always #12.5 mclk = ~mclk;
  assign {display_ram_write, count_read_n, count_source_write_n, timing_read_n, timing_write_n,
    divider_high_load_n, divider_low_load_n, power_detect_write_n, power_detect_read_n,
    keypad_read_n, analog_out_load_n, trigger_decoder_enable_n} = stb;
  cbsc_cpu cpu (.mclk(mclk), .stb(stb), .address_bus(address_bus), .data_in(data_in),
    .display_blank_reset_n(display_blank_reset_n),
    .interface_card_select_n(interface_card_select_n));
  cbsc_top dut (.*);
  function automatic logic [15:0] obs(logic [3:0] s);
    case (s)
      4'h0: obs = {8'h00, timing_reg};
      4'h1: obs = divide_n;
      4'h2: obs = {8'h00, analog_out};
      4'h3: obs = {8'h00, data_out};
      4'h4: obs = {15'h0000, count_source_if};
      4'h5: obs = {15'h0000, detect_active};
      4'h6: obs = {15'h0000, data_oe};
      4'h7: obs = {15'h0000, display_blank};
      4'h8: obs = {15'h0000, trigger_enable};
      4'h9: obs = {15'h0000, interface_enable};
      4'ha: obs = {15'h0000, interrupt_request_n};
      4'hc: obs = {14'h0000, direct_div4, direct_div2};
      4'hd: obs = {14'h0000, direct_gate_n, if_gate_n};
      4'he: obs = {15'h0000, narrow_filter};
      4'hf: obs = {8'h00, display_data};
      default: obs = {15'h0000, oscillator_select};
    endcase
  endfunction
  task automatic expect_at(logic [3:0] s, logic [15:0] v);
    sel_q.push_back(s);
    exp_q.push_back(v);
    -> probe_ev;
  endtask
  // Watcher takes the oldest note when a result is due
  always @(probe_ev) begin
    // Several notes may arrive in one time step
    while (sel_q.size() > 0) begin
      cmp_count++;
      if (obs(sel_q[0]) !== exp_q[0]) begin
        miscompares++;
        $display("wrong value at %0t: output %0d is %h, want %h", $time, sel_q[0],
          obs(sel_q[0]), exp_q[0]);
      end
      void'(sel_q.pop_front());
      void'(exp_q.pop_front());
    end
  end
  // Mid-cycle probe for reads and level strobes such as power write, after-release probe for edge-loaded writes
  task automatic op(int idx, logic [7:0] dd, logic mid, logic [3:0] s, logic [15:0] v);
    cpu.begin_cycle(idx, 16'($random(seed)), dd);
    repeat (4) @(posedge mclk);
    #1;
    if (mid) expect_at(s, v);
    cpu.end_cycle();
    repeat (4) @(posedge mclk);
    #1;
    if (!mid) expect_at(s, v);
  endtask
  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    stop_test();
  end
  initial begin
    {key_pending, interface_irq, gate_open, direct_in, if_in} = 5'h00;
    keypad_code = 8'h00;
    power_level = 8'h00;
    lo = 8'h00;
    repeat (8) @(posedge mclk);
    #1;
    expect_at(4'h7, 16'h0001);
    @(posedge mclk);
    arst_n <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      d = 8'($random(seed));
      e = 8'($random(seed));
      op(7, d, 1'b0, 4'h0, {8'h00, d});
      op(6, d, 1'b0, 4'h1, {d, lo});
      op(5, e, 1'b0, 4'h1, {d, e});
      lo = e;
      op(1, e, 1'b0, 4'h2, {8'h00, e});
      op(9, d, 1'b0, 4'h4, {15'h0000, d[0]});
      pl = 8'($random(seed));
      kc = 8'($random(seed));
      if (d[1] && !dir_lvl) dir_edges++;
      dir_lvl = d[1];
      @(posedge mclk);
      power_level <= pl;
      keypad_code <= kc;
      direct_in <= d[1];
      if_in <= e[1];
      op(3, d, 1'b1, 4'h3, {8'h00, pl});
      op(2, d, 1'b1, 4'h3, {8'h00, kc});
      expect_at(4'h6, 16'h0000);
      op(10, d, 1'b1, 4'h6, 16'h0001);
      op(8, d, 1'b1, 4'h3, {8'h00, d});
      op(4, d, 1'b1, 4'h5, 16'h0001);
      expect_at(4'he, {15'h0000, !d[0]});
      expect_at(4'hc, {14'h0000, dir_edges[1:0]});
    end
    op(12, d, 1'b1, 4'h7, 16'h0001);
    op(0, d, 1'b1, 4'h8, 16'h0001);
    op(13, d, 1'b1, 4'h9, 16'h0001);
    for (int j = 0; j < 3; j++) begin
      @(posedge mclk);
      key_pending <= (j == 0);
      interface_irq <= (j == 1);
      repeat (4) @(posedge mclk);
      #1;
      expect_at(4'ha, {15'h0000, j == 2});
    end
    // Long fill covers every RAM byte
    cpu.begin_cycle(11, 16'h0000, kc);
    repeat (20) @(posedge mclk);
    cpu.end_cycle();
    repeat (4) @(posedge mclk);
    #1;
    expect_at(4'hf, {8'h00, kc});
    @(posedge mclk);
    gate_open <= 1'b1;
    repeat (4) @(posedge mclk);
    #1;
    expect_at(4'hb, 16'h0001);
    expect_at(4'hd, {14'h0000, d[0], !d[0]});
    #1;
    stop_test();
  end
endmodule // test_counter_bus_strobe_control
